/* tmw_pkg.sv */
/*
 * Shared constants and types for the 8-bit timer waveform block.
 * Assumes a single 10 MHz clock and classic Wishbone register access.
 */
package tmw_pkg;

  // ****************************************
  // Register word offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] TMW_CTRL_OFS = 8'h00;
  localparam logic [7:0] TMW_CNT_OFS = 8'h04;
  localparam logic [7:0] TMW_CMPA_OFS = 8'h08;
  localparam logic [7:0] TMW_CMPB_OFS = 8'h0C;
  localparam logic [7:0] TMW_FLAG_OFS = 8'h10;
  localparam logic [7:0] TMW_PORT_OFS = 8'h14;
  localparam logic [7:0] TMW_FORCE_OFS = 8'h18;

  // ****************************************
  // Control, flag and force field positions
  // ****************************************
  localparam int TMW_MODE_A_POS = 6;
  localparam int TMW_MODE_B_POS = 4;
  localparam int TMW_WAVE_POS = 0;
  localparam int TMW_RUN_POS = 8;
  localparam int TMW_FLAG_OVF_POS = 0;
  localparam int TMW_FLAG_A_POS = 1;
  localparam int TMW_FLAG_B_POS = 2;
  localparam int TMW_FORCE_A_POS = 0;
  localparam int TMW_FORCE_B_POS = 1;

  // ****************************************
  // Counter boundaries and reset values
  // ****************************************
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  localparam logic [7:0] TMW_MAX = 8'hFF;
  localparam logic [8:0] TMW_CTRL_RST = 9'h000;
  localparam logic [7:0] TMW_BYTE_RST = 8'h00;

  // ****************************************
  // Waveform modes
  // ****************************************
  typedef enum logic [2:0] {
    TMW_WAVE_NORMAL = 3'b000,
    TMW_WAVE_PC1 = 3'b001,
    TMW_WAVE_CLEAR = 3'b010,
    TMW_WAVE_FAST = 3'b011,
    TMW_WAVE_R4 = 3'b100,
    TMW_WAVE_PC5 = 3'b101,
    TMW_WAVE_R6 = 3'b110,
    TMW_WAVE_FAST_A = 3'b111
  } tmw_wave_type;

  // Compare output action codes
  localparam logic [1:0] TMW_COM_OFF = 2'h0;
  localparam logic [1:0] TMW_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMW_COM_SET = 2'h3;

  // Pin-side group for one channel
  typedef struct packed {
    logic drive;
    logic level;
    logic enable;
  } tmw_pin_type;

endpackage

/* tmw_timer.sv */
/*
 * 8-bit timer: counter, compare match, waveform output and pin override.
 * Assumes a synchronous active-high reset and a classic Wishbone master;
 * the timer clock is a one-cycle enable from an outside prescaler.
 */
`timescale 1ns/1ps
`default_nettype none

module tmw_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timer clock enable from prescaler
  input wire logic tick_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Port pins
  output var tmw_pkg::tmw_pin_type pin_a_o,
  output var tmw_pkg::tmw_pin_type pin_b_o,
  // Flag levels
  output logic ovf_o,
  output logic cmp_a_flag_o,
  output logic cmp_b_flag_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0] mode_a_reg;
  logic [1:0] mode_b_reg;
  tmw_pkg::tmw_wave_type wave_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cmp_a_reg;
  logic [7:0] cmp_b_reg;
  logic [7:0] buf_a_reg;
  logic [7:0] buf_b_reg;
  logic ovf_reg;
  logic flag_a_reg;
  logic flag_b_reg;
  logic oc_a_reg;
  logic oc_b_reg;
  logic [1:0] port_out_reg;
  logic [1:0] port_dir_reg;
  logic block_reg;
  logic pend_a_reg;
  logic pend_b_reg;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_fast(input tmw_pkg::tmw_wave_type w);
    return (w == tmw_pkg::TMW_WAVE_FAST) || (w == tmw_pkg::TMW_WAVE_FAST_A);
  endfunction

  // Next compare state for a non-PWM action code
  function automatic logic nonpwm_act(input logic [1:0] m,
                                      input logic cur);
    logic r;
    r = cur;
    unique case (m)
      tmw_pkg::TMW_COM_OFF: r = cur;
      tmw_pkg::TMW_COM_TOGGLE: r = ~cur;
      tmw_pkg::TMW_COM_CLEAR: r = 1'b0;
      tmw_pkg::TMW_COM_SET: r = 1'b1;
    endcase
    return r;
  endfunction

  logic wr;
  logic rd_cycle;
  logic fast;
  logic [7:0] top;
  logic at_top;
  logic match_a;
  logic match_b;
  logic cnt_wr;
  logic [7:0] wdat;

  assign wr = cyc_i && stb_i && we_i && !ack_o;
  assign rd_cycle = cyc_i && stb_i && !ack_o;
  assign wdat = sel_i[0] ? dat_i[7:0] : 8'h00;
  assign fast = is_fast(wave_reg);
  assign top = (wave_reg == tmw_pkg::TMW_WAVE_FAST) ? tmw_pkg::TMW_MAX :
               cmp_a_reg;
  assign at_top = (cnt_reg == top);
  assign cnt_wr = wr && sel_i[0] && (adr_i == tmw_pkg::TMW_CNT_OFS);
  // Match only on timer cycles, not on the first tick after a counter write
  assign match_a = tick_i && !block_reg && (cnt_reg == cmp_a_reg);
  assign match_b = tick_i && !block_reg && (cnt_reg == cmp_b_reg);

  // ****************************************
  // Wishbone acknowledge and read data
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= rd_cycle;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_cycle && !we_i) begin
      unique case (adr_i)
        tmw_pkg::TMW_CTRL_OFS:
          dat_o <= {24'h000000, mode_a_reg, mode_b_reg, 1'b0,
                    wave_reg};
        tmw_pkg::TMW_CNT_OFS: dat_o <= {24'h000000, cnt_reg};
        tmw_pkg::TMW_CMPA_OFS:
          dat_o <= {24'h000000, fast ? buf_a_reg : cmp_a_reg};
        tmw_pkg::TMW_CMPB_OFS:
          dat_o <= {24'h000000, fast ? buf_b_reg : cmp_b_reg};
        tmw_pkg::TMW_FLAG_OFS:
          dat_o <= {24'h000000, 5'h00, flag_b_reg, flag_a_reg, ovf_reg};
        tmw_pkg::TMW_PORT_OFS:
          dat_o <= {24'h000000, 2'h0, oc_b_reg, oc_a_reg, port_dir_reg,
                    port_out_reg};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Control fields
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_a_reg <= 2'h0;
      mode_b_reg <= 2'h0;
      wave_reg <= tmw_pkg::TMW_WAVE_NORMAL;
    end else if (wr && sel_i[0] && adr_i == tmw_pkg::TMW_CTRL_OFS) begin
      // Mode bits act from the next cycle, no buffering
      mode_a_reg <= dat_i[tmw_pkg::TMW_MODE_A_POS +: 2];
      mode_b_reg <= dat_i[tmw_pkg::TMW_MODE_B_POS +: 2];
      wave_reg <= tmw_pkg::tmw_wave_type'(dat_i[tmw_pkg::TMW_WAVE_POS +: 3]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_out_reg <= 2'h0;
      port_dir_reg <= 2'h0;
    end else if (wr && sel_i[0] && adr_i == tmw_pkg::TMW_PORT_OFS) begin
      port_out_reg <= dat_i[1:0];
      port_dir_reg <= dat_i[3:2];
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= tmw_pkg::TMW_BYTE_RST;
    end else if (cnt_wr) begin
      cnt_reg <= wdat;
    end else if (tick_i) begin
      if (wave_reg == tmw_pkg::TMW_WAVE_CLEAR && cnt_reg == cmp_a_reg) begin
        cnt_reg <= tmw_pkg::TMW_BOTTOM;
      end else if (fast && at_top) begin
        cnt_reg <= tmw_pkg::TMW_BOTTOM;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;
    end else if (tick_i) begin
      block_reg <= 1'b0;
    end
  end

  // ****************************************
  // Compare values, buffered in fast PWM
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_a_reg <= tmw_pkg::TMW_BYTE_RST;
      buf_b_reg <= tmw_pkg::TMW_BYTE_RST;
    end else if (wr && sel_i[0]) begin
      if (adr_i == tmw_pkg::TMW_CMPA_OFS) begin
        buf_a_reg <= dat_i[7:0];
      end
      if (adr_i == tmw_pkg::TMW_CMPB_OFS) begin
        buf_b_reg <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_a_reg <= tmw_pkg::TMW_BYTE_RST;
      cmp_b_reg <= tmw_pkg::TMW_BYTE_RST;
    end else if (!fast) begin
      // Direct write outside fast PWM
      if (wr && sel_i[0] && adr_i == tmw_pkg::TMW_CMPA_OFS) begin
        cmp_a_reg <= dat_i[7:0];
      end
      if (wr && sel_i[0] && adr_i == tmw_pkg::TMW_CMPB_OFS) begin
        cmp_b_reg <= dat_i[7:0];
      end
    end else if (tick_i && at_top) begin
      // Update as the counter restarts from bottom
      cmp_a_reg <= buf_a_reg;
      cmp_b_reg <= buf_b_reg;
    end
  end

  // ****************************************
  // Flags: hardware sets, software writes one to clear
  // ****************************************
  logic ovf_set;
  logic [2:0] clr;

  assign clr = (wr && sel_i[0] && adr_i == tmw_pkg::TMW_FLAG_OFS) ?
               dat_i[2:0] : 3'h0;
  // Normal and clear-on-match: count passes 0xFF; fast PWM: reaches top
  assign ovf_set = tick_i && !cnt_wr &&
                   (fast ? at_top : cnt_reg == tmw_pkg::TMW_MAX);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
    end else if (ovf_set) begin
      ovf_reg <= 1'b1;
    end else if (clr[tmw_pkg::TMW_FLAG_OVF_POS]) begin
      ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_a_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end else if (tick_i) begin
      pend_a_reg <= match_a;
      pend_b_reg <= match_b;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else begin
      if (tick_i && pend_a_reg) begin
        flag_a_reg <= 1'b1;
      end else if (clr[tmw_pkg::TMW_FLAG_A_POS]) begin
        flag_a_reg <= 1'b0;
      end
      if (tick_i && pend_b_reg) begin
        flag_b_reg <= 1'b1;
      end else if (clr[tmw_pkg::TMW_FLAG_B_POS]) begin
        flag_b_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Waveform generator
  // ****************************************
  logic force_a;
  logic force_b;
  logic restart;

  assign force_a = wr && sel_i[0] && !fast &&
                   adr_i == tmw_pkg::TMW_FORCE_OFS &&
                   dat_i[tmw_pkg::TMW_FORCE_A_POS];
  assign force_b = wr && sel_i[0] && !fast &&
                   adr_i == tmw_pkg::TMW_FORCE_OFS &&
                   dat_i[tmw_pkg::TMW_FORCE_B_POS];
  assign restart = tick_i && fast && at_top;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_a_reg <= 1'b0;
    end else if (!fast) begin
      if (match_a || force_a) begin
        oc_a_reg <= nonpwm_act(mode_a_reg, oc_a_reg);
      end
    end else if (mode_a_reg[1]) begin
      // Match ignored when compare equals top; bottom sets level
      if (restart) begin
        oc_a_reg <= ~mode_a_reg[0];
      end else if (match_a && cmp_a_reg != top) begin
        oc_a_reg <= mode_a_reg[0];
      end
    end else if (mode_a_reg[0] && wave_reg[2] && match_a) begin
      oc_a_reg <= ~oc_a_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_b_reg <= 1'b0;
    end else if (!fast) begin
      if (match_b || force_b) begin
        oc_b_reg <= nonpwm_act(mode_b_reg, oc_b_reg);
      end
    end else if (mode_b_reg[1]) begin
      if (restart) begin
        oc_b_reg <= ~mode_b_reg[0];
      end else if (match_b && cmp_b_reg != top) begin
        oc_b_reg <= mode_b_reg[0];
      end
    end
  end

  // ****************************************
  // Pin override and flag outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_o <= '0;
      pin_b_o <= '0;
      ovf_o <= 1'b0;
      cmp_a_flag_o <= 1'b0;
      cmp_b_flag_o <= 1'b0;
    end else begin
      pin_a_o.drive <= port_dir_reg[0];
      pin_a_o.level <= (mode_a_reg != 2'h0) ? oc_a_reg : port_out_reg[0];
      pin_a_o.enable <= (mode_a_reg != 2'h0);
      pin_b_o.drive <= port_dir_reg[1];
      pin_b_o.level <= (mode_b_reg != 2'h0) ? oc_b_reg : port_out_reg[1];
      pin_b_o.enable <= (mode_b_reg != 2'h0);
      ovf_o <= ovf_reg;
      cmp_a_flag_o <= flag_a_reg;
      cmp_b_flag_o <= flag_b_reg;
    end
  end

endmodule

`default_nettype wire

/* tmw_timer_props.sv */
/* Port assertions for tmw_timer.
   Bound to the timer; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module tmw_timer_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timer enable and bus
  input wire logic tick_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins and flags
  input wire tmw_pkg::tmw_pin_type pin_a_o,
  input wire tmw_pkg::tmw_pin_type pin_b_o,
  input wire logic ovf_o,
  input wire logic cmp_a_flag_o,
  input wire logic cmp_b_flag_o
);
  logic req;
  logic [3:0] fw_reg;
  logic [3:0] pw_reg;
  assign req = cyc_i && stb_i && we_i && !ack_o;
  // Recent flag and port writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fw_reg <= 4'h0;
      pw_reg <= 4'h0;
    end else begin
      fw_reg <= {fw_reg[2:0], req && adr_i == tmw_pkg::TMW_FLAG_OFS};
      pw_reg <= {pw_reg[2:0], req && adr_i == tmw_pkg::TMW_PORT_OFS};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held over one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  reset_clear_a: assert property (
    $fell(rst_i) |-> !pin_a_o && !pin_b_o && !ovf_o)
    else $error("outputs not cleared by reset");
  ovf_hold_a: assert property ($fell(ovf_o) |-> |fw_reg)
    else $error("overflow flag dropped without a write");
  flag_a_hold_a: assert property ($fell(cmp_a_flag_o) |-> |fw_reg)
    else $error("compare A flag dropped without a write");
  flag_b_hold_a: assert property ($fell(cmp_b_flag_o) |-> |fw_reg)
    else $error("compare B flag dropped without a write");
  dir_follow_a: assert property ($changed(pin_a_o.drive) |-> |pw_reg)
    else $error("pin direction moved without a port write");
  port_level_a: assert property (!pin_a_o.enable &&
    $stable(pin_a_o.enable) && $changed(pin_a_o.level) |-> |pw_reg)
    else $error("released pin level moved without a port write");
  cover property ($rose(ovf_o));
  cover property ($rose(cmp_a_flag_o));
  cover property ($rose(pin_a_o.enable));
endmodule
bind tmw_timer tmw_timer_props tmw_timer_props_inst (.clk_i(clk_i),
  .rst_i(rst_i), .tick_i(tick_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .pin_a_o(pin_a_o), .pin_b_o(pin_b_o),
  .ovf_o(ovf_o), .cmp_a_flag_o(cmp_a_flag_o),
  .cmp_b_flag_o(cmp_b_flag_o));
`default_nettype wire

/* tmw_port_pad.sv */
/* Port pad model for the two compare pins.
   Assumes pin groups from tmw_timer; no pull on the pads. */
`timescale 1ns/1ps
`default_nettype none
module tmw_port_pad (
  // Clock
  input wire logic clk_i,
  // Pin groups from the timer
  input wire tmw_pkg::tmw_pin_type pin_a_i,
  input wire tmw_pkg::tmw_pin_type pin_b_i,
  // Pad levels
  output logic pad_a_o,
  output logic pad_b_o
);
  logic last_a_reg = 1'b0;
  logic last_b_reg = 1'b0;
  always_ff @(posedge clk_i) begin
    last_a_reg <= pad_a_o;
    last_b_reg <= pad_b_o;
  end
  // Undriven pad wanders
  assign pad_a_o = pin_a_i.drive ? pin_a_i.level : ~last_a_reg;
  assign pad_b_o = pin_b_i.drive ? pin_b_i.level : ~last_b_reg;
endmodule
`default_nettype wire

/* test_timer8_waveform_modes.sv */
/* Self-checking bench for tmw_timer with the pad model.
   Assumes package, design, checker and pad model compile first. */
`timescale 1ns/1ps
`default_nettype none
module test_timer8_waveform_modes;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tick_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  tmw_pkg::tmw_pin_type pin_a_o;
  tmw_pkg::tmw_pin_type pin_b_o;
  logic ovf_o;
  logic cmp_a_flag_o;
  logic cmp_b_flag_o;
  logic pad_a;
  logic pad_b;
  logic [7:0] rv;
  logic [7:0] c;
  logic st;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int top;
  int k;
  int n;
  int clr;
  tmw_timer tmw_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_a_o(pin_a_o), .pin_b_o(pin_b_o), .ovf_o(ovf_o),
    .cmp_a_flag_o(cmp_a_flag_o), .cmp_b_flag_o(cmp_b_flag_o));
  tmw_port_pad tmw_port_pad_inst (.clk_i(clk_i), .pin_a_i(pin_a_o),
    .pin_b_i(pin_b_o), .pad_a_o(pad_a), .pad_b_o(pad_b));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rv = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic ticks(input int t);
    repeat (t) begin
      @(posedge clk_i);
      tick_i <= 1'b1;
      @(posedge clk_i);
      tick_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] ctc_next(input logic [7:0] v, input int t);
    return (v == t[7:0]) ? 8'h00 : v + 8'h01;
  endfunction
  function automatic logic pwm_lvl(input int m, input logic [7:0] v);
    return (v < 8'h40) ^ (m == 3);
  endfunction
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h650E0216));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, tmw_pkg::TMW_CTRL_OFS, 8'h00);
    chk("ctrl", 8'h00, rv);
    chk("pin a", 8'h00, 8'(pin_a_o));
    $display("reset test done");
    wb(1, tmw_pkg::TMW_PORT_OFS, 8'h0C);
    wb(1, tmw_pkg::TMW_CTRL_OFS, 8'hF0);
    wb(1, tmw_pkg::TMW_FORCE_OFS, 8'h03);
    repeat (3) @(posedge clk_i);
    chk("force", 8'h01, 8'(pad_a));
    chk("force b", 8'h01, 8'(pad_b));
    wb(1, tmw_pkg::TMW_CNT_OFS, 8'hFE);
    ticks(2);
    wb(0, tmw_pkg::TMW_CNT_OFS, 8'h00);
    chk("wrap", 8'h00, rv);
    wb(0, tmw_pkg::TMW_FLAG_OFS, 8'h00);
    chk("ovf", 8'h01, 8'(rv[0]));
    chk("ovf out", 8'h01, 8'(ovf_o));
    wb(1, tmw_pkg::TMW_CMPB_OFS, 8'h05);
    wb(1, tmw_pkg::TMW_CNT_OFS, 8'h05);
    ticks(2);
    wb(0, tmw_pkg::TMW_FLAG_OFS, 8'h00);
    chk("blocked", 8'h00, 8'(rv[2]));
    wb(1, tmw_pkg::TMW_CNT_OFS, 8'h04);
    ticks(3);
    wb(0, tmw_pkg::TMW_FLAG_OFS, 8'h00);
    chk("cmp b", 8'h01, 8'(rv[2]));
    chk("cmp b out", 8'h01, 8'(cmp_b_flag_o));
    $display("normal test done");
    wb(1, tmw_pkg::TMW_FLAG_OFS, 8'h07);
    top = $urandom_range(20, 3);
    k = $urandom_range(45, 1);
    wb(1, tmw_pkg::TMW_CTRL_OFS, 8'h42);
    wb(1, tmw_pkg::TMW_CMPA_OFS, top[7:0]);
    wb(1, tmw_pkg::TMW_CNT_OFS, 8'h00);
    c = 8'h00;
    clr = 0;
    n = 0;
    while (n < k || c == top[7:0] || c == 8'h00) begin
      clr += int'(c == top[7:0]);
      c = ctc_next(c, top);
      n++;
    end
    ticks(n);
    st = ~clr[0];
    wb(0, tmw_pkg::TMW_CNT_OFS, 8'h00);
    chk("ctc cnt", c, rv);
    wb(0, tmw_pkg::TMW_FLAG_OFS, 8'h00);
    chk("ctc flag", 8'(clr > 0), 8'(rv[1]));
    chk("ctc flag out", 8'(clr > 0), 8'(cmp_a_flag_o));
    chk("toggle", 8'(st), 8'(pad_a));
    wb(1, tmw_pkg::TMW_FLAG_OFS, 8'h07);
    wb(1, tmw_pkg::TMW_CNT_OFS, 8'hFE);
    ticks(2);
    wb(0, tmw_pkg::TMW_CNT_OFS, 8'h00);
    chk("ctc wrap", 8'h00, rv);
    wb(0, tmw_pkg::TMW_FLAG_OFS, 8'h00);
    chk("ctc ovf", 8'h01, 8'(rv[0]));
    wb(1, tmw_pkg::TMW_CTRL_OFS, 8'h02);
    wb(1, tmw_pkg::TMW_PORT_OFS, {7'h06, ~st});
    ticks(top + 2);
    wb(0, tmw_pkg::TMW_PORT_OFS, 8'h00);
    chk("hold", 8'(st), 8'(rv[4]));
    chk("port", 8'(!st), 8'(pad_a));
    chk("port b", 8'h00, 8'(pad_b));
    $display("clear test done");
    for (int m = 2; m < 4; m++) begin
      wb(1, tmw_pkg::TMW_CTRL_OFS, {m[1:0], 6'h03});
      wb(1, tmw_pkg::TMW_CMPA_OFS, 8'h40);
      wb(1, tmw_pkg::TMW_CNT_OFS, 8'hF0);
      wb(1, tmw_pkg::TMW_FLAG_OFS, 8'h07);
      ticks(16);
      wb(0, tmw_pkg::TMW_FLAG_OFS, 8'h00);
      chk("pwm ovf", 8'h01, 8'(rv[0]));
      ticks(32);
      wb(0, tmw_pkg::TMW_CNT_OFS, 8'h00);
      chk("pwm cnt", 8'h20, rv);
      chk("pwm early", 8'(pwm_lvl(m, 8'h20)), 8'(pad_a));
      ticks(48);
      chk("pwm late", 8'(pwm_lvl(m, 8'h50)), 8'(pad_a));
    end
    wb(1, tmw_pkg::TMW_CTRL_OFS, 8'h47);
    wb(1, tmw_pkg::TMW_CNT_OFS, 8'h3E);
    wb(1, tmw_pkg::TMW_CMPA_OFS, 8'h04);
    n = $urandom_range(9, 1);
    ticks(3 + 5 * n);
    chk("fast toggle", 8'(n[0]), 8'(pad_a));
    $display("pwm test done");
    stop_test();
  end
endmodule
`default_nettype wire
